/* verilog/sdpdc_top.sv */
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - CKE low enters, CKE high leaves power-down
// - Accept entry while busy, low power after
// - Power-down disables input and output buffers
// - Clock kept tCKELCK, then receivers turn off
// - No refresh outside self-refresh power-down; code also keeps refresh on whenever not in power-down
// - Idle or active power-down by bank state
// - Self-refresh power-down keeps refreshing
// - Command-bus termination stays on throughout
module sdpdc_top #(
  parameter int TIMER_W = 4,
  parameter int PULSE_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdpdc_pkg::sdpdc_wb_req_type wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic cke_pin_i,
  input wire logic cs_pin_i,
  input wire logic bank_open_i,
  input wire logic self_refresh_i,
  input wire logic op_busy_i,
  input wire logic vddq_ok_i,
  output logic pd_o,
  output sdpdc_pkg::sdpdc_mode_type pd_mode_o,
  output logic buf_en_o,
  output logic rx_en_o,
  output logic low_pwr_o,
  output logic refresh_en_o,
  output logic term_en_o,
  output logic cmd_en_o
);
  import sdpdc_pkg::*;

  if (CKELCK_CYC > 2 ** TIMER_W || XP_CYC > 2 ** TIMER_W) begin : g_chk_t
    $error("sdpdc_top: TIMER_W too small for timing counts");
  end
  if (CKE_CYC >= 2 ** PULSE_W) begin : g_chk_p
    $error("sdpdc_top: PULSE_W too small for pulse count");
  end

  // ==========================================================
  // Pin capture, both pins come from the far side
  logic cke_s, cs_s;

  sdpdc_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({cke_pin_i, cs_pin_i}),
    .q_o({cke_s, cs_s})
  );

  // ==========================================================
  // Power-down state machine
  sdpdc_state_type state_q, state_d;
  sdpdc_mode_type mode_q, mode_d;
  logic tmr_load, tmr_done;
  logic [TIMER_W-1:0] tmr_val;

  // One shared timer; only one guarded window is open at a time
  sdpdc_timer #(.W(TIMER_W)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    case (state_q)
      ST_ACT: begin
        if (!cke_s) begin
          state_d = ST_ENT;
          mode_d = self_refresh_i ? MODE_SELF : (bank_open_i ? MODE_ACTV : MODE_IDLE);
        end
      end
      ST_ENT: begin
        if (cke_s) begin
          state_d = ST_EXT;
        end else if (tmr_done) begin
          state_d = ST_PD;
        end
      end
      ST_PD: begin
        if (cke_s) begin
          state_d = ST_EXT;
        end
      end
      ST_EXT: begin
        if (!cke_s) begin
          state_d = ST_ENT;
        end else if (tmr_done) begin
          state_d = ST_ACT;
          mode_d = MODE_NONE;
        end
      end
      default: begin
        state_d = ST_PD;
        mode_d = MODE_NONE;
      end
    endcase
  end

  // Timer reloads on every state change into a timed state
  always_comb begin
    tmr_load = (state_d != state_q) && (state_d == ST_ENT || state_d == ST_EXT);
    tmr_val = (state_d == ST_ENT) ? TIMER_W'(CKELCK_CYC - 1) : TIMER_W'(XP_CYC - 1);
  end

  // Reset lands in power-down: CKE is expected low until the first exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_PD;
      mode_q <= MODE_IDLE;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // Pulse width and exit latency monitors
  logic cke_prev_q, cke_prev_d;
  logic [PULSE_W-1:0] pulse_q, pulse_d;
  logic cke_edge;

  // Counter saturates so long pulses never wrap into a false short one
  always_comb begin
    cke_edge = (cke_s != cke_prev_q);
    cke_prev_d = cke_s;
    if (cke_edge) begin
      pulse_d = PULSE_W'(1);
    end else if (pulse_q < PULSE_W'(CKE_CYC)) begin
      pulse_d = pulse_q + PULSE_W'(1);
    end else begin
      pulse_d = pulse_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_prev_q <= 1'b0;
      pulse_q <= PULSE_W'(CKE_CYC);
    end else begin
      cke_prev_q <= cke_prev_d;
      pulse_q <= pulse_d;
    end
  end

  // ==========================================================
  // Registered outputs, computed from the next state; termination from the setting and supply
  logic [CTRL_TERM_SEC:0] ctrl_q, ctrl_d;
  logic term_ok;
  logic pd_d, buf_d, rx_d, lowp_d, refr_d, term_d, cmd_d;

  always_comb begin
    term_ok = (ctrl_q[CTRL_TERM_SEC-1:CTRL_TERM_LSB] != 3'h0) && ctrl_q[CTRL_TERM_SEC];
    term_d = term_ok && vddq_ok_i;
  end

  always_comb begin
    pd_d = (state_d == ST_ENT) || (state_d == ST_PD);
    buf_d = (state_d == ST_ACT) || (state_d == ST_EXT);
    rx_d = (state_d != ST_PD);
    lowp_d = (state_d == ST_PD) && !op_busy_i;
    refr_d = !pd_d || (mode_d == MODE_SELF);
    cmd_d = (state_d == ST_ACT);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_o <= 1'b1;
      pd_mode_o <= MODE_IDLE;
      buf_en_o <= 1'b0;
      rx_en_o <= 1'b0;
      low_pwr_o <= 1'b0;
      refresh_en_o <= 1'b0;
      term_en_o <= 1'b0;
      cmd_en_o <= 1'b0;
    end else begin
      pd_o <= pd_d;
      pd_mode_o <= mode_d;
      buf_en_o <= buf_d;
      rx_en_o <= rx_d;
      low_pwr_o <= lowp_d;
      refresh_en_o <= refr_d;
      term_en_o <= term_d;
      cmd_en_o <= cmd_d;
    end
  end

  // ==========================================================
  // Wishbone slave: one wait state, unmapped reads as zero
  logic ack_d;
  logic [31:0] dat_d;
  logic [1:0] err_q, err_d, err_set;
  logic wr_hit;

  always_comb begin
    ack_d = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    // Write lands on the edge where the master sees ack, request still held
    wr_hit = wb_ack_o && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0];
    dat_d = 32'h0000_0000;
    if (ack_d && !wb_req_i.we) begin
      case (wb_req_i.adr)
        REG_CTRL: dat_d[CTRL_TERM_SEC:0] = ctrl_q;
        REG_STATUS: begin
          dat_d[STAT_PD] = pd_o;
          dat_d[STAT_MODE_LSB+:2] = pd_mode_o;
          dat_d[STAT_RX] = rx_en_o;
          dat_d[STAT_BUF] = buf_en_o;
          dat_d[STAT_LOWPWR] = low_pwr_o;
          dat_d[STAT_REFR] = refresh_en_o;
          dat_d[STAT_TERM] = term_en_o;
        end
        REG_ERR: dat_d[1:0] = err_q;
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Sticky faults from the far side; a new fault beats a same-cycle clear
  always_comb begin
    err_set[ERR_PULSE] = cke_edge && (pulse_q < PULSE_W'(CKE_CYC));
    err_set[ERR_EARLY_CMD] = (state_q == ST_EXT) && cs_s;
    ctrl_d = ctrl_q;
    err_d = err_q;
    if (wr_hit && wb_req_i.adr == REG_CTRL) begin
      ctrl_d = wb_req_i.dat[CTRL_TERM_SEC:0];
    end
    if (wr_hit && wb_req_i.adr == REG_ERR) begin
      err_d = err_q & ~wb_req_i.dat[1:0];
    end
    err_d = err_d | err_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      err_q <= ERR_RST;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
      ctrl_q <= ctrl_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_enter;
    (state_q == ST_ACT) && !cke_s;
  endsequence

  sequence s_hold_low;
    (!cke_s) [*5];
  endsequence

  chk_entry_on_low: assert property (s_enter |=> pd_o)
    else $error("power-down not entered on CKE low");
  chk_rx_window: assert property (s_enter |=> rx_en_o [*5])
    else $error("receivers dropped before window end");
  chk_rx_off: assert property (s_enter ##1 s_hold_low |=> !rx_en_o)
    else $error("receivers still on after window");
  chk_buf_off: assert property (pd_o |-> !buf_en_o)
    else $error("buffers on in power-down");
  chk_low_power: assert property (low_pwr_o |-> !rx_en_o && !$past(op_busy_i))
    else $error("low power while busy");
  chk_mode_class: assert property ((s_enter and !self_refresh_i) |=>
      pd_mode_o == ($past(bank_open_i) ? MODE_ACTV : MODE_IDLE))
    else $error("wrong power-down mode");
  chk_self_refresh: assert property (pd_o && pd_mode_o == MODE_SELF |-> refresh_en_o)
    else $error("refresh stopped in self-refresh power-down");
  chk_no_refresh: assert property (pd_o && pd_mode_o != MODE_SELF |-> !refresh_en_o)
    else $error("refresh in plain power-down");
  chk_term_kept: assert property (term_ok && vddq_ok_i |=> term_en_o)
    else $error("termination dropped");
  chk_exit_latency: assert property ((state_q == ST_PD) && cke_s |=> !cmd_en_o [*5])
    else $error("command enabled before exit latency");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

/* shared/sdpdc_pkg.sv */
package sdpdc_pkg;

  // ==========================================================
  // Timing, all figures in picoseconds or clock counts
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned T_CKELCK_PS = 5000;
  localparam int unsigned N_CKELCK_NCK = 5;
  localparam int unsigned T_CKE_PS = 7500;
  localparam int unsigned N_CKE_NCK = 4;
  localparam int unsigned T_XP_PS = 7500;
  localparam int unsigned N_XP_NCK = 5;

  // Round analog time up, then take the larger with the clock count
  function automatic int unsigned cyc_min(input int unsigned ps, input int unsigned nck);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return (c > nck) ? c : nck;
  endfunction

  localparam int unsigned CKELCK_CYC = cyc_min(T_CKELCK_PS, N_CKELCK_NCK);
  localparam int unsigned CKE_CYC = cyc_min(T_CKE_PS, N_CKE_NCK);
  localparam int unsigned XP_CYC = cyc_min(T_XP_PS, N_XP_NCK);

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam int CTRL_TERM_LSB = 0;
  localparam int CTRL_TERM_SEC = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int STAT_PD = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_RX = 3;
  localparam int STAT_BUF = 4;
  localparam int STAT_LOWPWR = 5;
  localparam int STAT_REFR = 6;
  localparam int STAT_TERM = 7;
  localparam int ERR_PULSE = 0;
  localparam int ERR_EARLY_CMD = 1;
  localparam logic [1:0] ERR_RST = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_ACT = 4'b0001,
    ST_ENT = 4'b0010,
    ST_PD = 4'b0100,
    ST_EXT = 4'b1000
  } sdpdc_state_type;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_IDLE = 2'h1,
    MODE_ACTV = 2'h2,
    MODE_SELF = 2'h3
  } sdpdc_mode_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sdpdc_wb_req_type;

endpackage

/* verilog/sdpdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sdpdc_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import sdpdc_pkg::*;

  // ==========================================================
  // Three-stage capture with agreement filter
  logic [W-1:0] s1_q, s2_q, s3_q, q_q;
  logic [W-1:0] q_d;

  if (W < 1) begin : g_chk
    $error("sdpdc_sync: W must be at least 1");
  end

  // A bit moves only once stages two and three agree, so a one-cycle glitch never counts
  always_comb begin
    q_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule
`default_nettype wire

/* verilog/sdpdc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sdpdc_timer #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  import sdpdc_pkg::*;

  // ==========================================================
  // Down counter that parks at zero
  logic [W-1:0] cnt_q, cnt_d;

  if (W < 2) begin : g_chk
    $error("sdpdc_timer: W must be at least 2");
  end

  // Load wins over the count, zero holds
  always_comb begin
    if (load_i) begin
      cnt_d = value_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

/* verification/sdpdc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Controller side of the CKE and CS pins
module sdpdc_ctrl_model
  import sdpdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic fault_i,
  input wire logic cmd_i,
  output logic cke_o,
  output logic cs_o
);
  logic cke_q, cke_d, cs_q, cs_d;
  logic [7:0] cnt_q, cnt_d, low_q, low_d;
  int unsigned pulse_min;

  // Next pin levels; fault mode breaks the spacing on purpose
  always_comb begin
    // each level held long enough, except in fault mode
    // A level lasts one cycle more than the count, so 2 gives a 3-cycle pulse
    pulse_min = fault_i ? 2 : CKE_CYC;
    cke_d = cke_q;
    if (go_i != cke_q && cnt_q >= pulse_min && (!cke_q || fault_i || low_q >= 8'h03)) begin
      cke_d = go_i;
    end
    cnt_d = (cke_d != cke_q) ? 8'h00 : ((cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01);
    // CS low gating, no spare cycle of margin
    cs_d = cke_d & go_i & cmd_i & (fault_i | (cnt_d > XP_CYC));
    low_d = cs_q ? 8'h00 : ((low_q == 8'hFF) ? low_q : low_q + 8'h01);
  end

  // clock never stops; bench wakes device often
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_q <= 1'b0;
      cs_q <= 1'b0;
      cnt_q <= 8'hFF;
      low_q <= 8'h00;
    end else begin
      cke_q <= cke_d;
      cs_q <= cs_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  assign cke_o = cke_q;
  assign cs_o = cs_q;
endmodule
`default_nettype wire

/* verification/sdpdc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module sdpdc_top_test;
  import sdpdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sdpdc_wb_req_type wb_req = '0;
  logic wb_ack, pd_o, buf_en, rx_en, low_pwr, refresh_en, term_en, cmd_en, cke, cs;
  logic [31:0] wb_dat;
  sdpdc_mode_type pd_mode;
  logic go = 1'b0, fault = 1'b0, cmd = 1'b0, bank_open = 1'b0, self_ref = 1'b0;
  logic op_busy = 1'b0, vddq_ok = 1'b1, exp_term = 1'b0;
  logic [31:0] seed = 32'hD2E3CE42, rnd_q = 32'hD2E3CE42;
  int failures = 0, n_compared = 0, cycles = 0;

  sdpdc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_dat), .cke_pin_i(cke), .cs_pin_i(cs), .bank_open_i(bank_open),
    .self_refresh_i(self_ref), .op_busy_i(op_busy), .vddq_ok_i(vddq_ok), .pd_o(pd_o),
    .pd_mode_o(pd_mode), .buf_en_o(buf_en), .rx_en_o(rx_en), .low_pwr_o(low_pwr),
    .refresh_en_o(refresh_en), .term_en_o(term_en), .cmd_en_o(cmd_en));
  sdpdc_ctrl_model ctrl (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .fault_i(fault),
    .cmd_i(cmd), .cke_o(cke), .cs_o(cs));

  // ==========================================================
  // Clock, random command traffic and hang guard
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rnd_q = lfsr(rnd_q);
    cmd <= rnd_q[0] | fault;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction

  // ==========================================================
  // Bus and sequence tasks
  task automatic wb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: adr, sel: 4'hF, dat: wd};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_dat;
    wb_req <= '0;
  endtask

  task automatic power_down(input logic sr, input logic bo);
    int n;
    sdpdc_mode_type m;
    logic [31:0] rd;
    m = sr ? MODE_SELF : (bo ? MODE_ACTV : MODE_IDLE);
    @(posedge clk_i);
    self_ref <= sr;
    bank_open <= bo;
    op_busy <= 1'b1;
    go <= 1'b0;
    @(negedge clk_i);
    while (pd_o !== 1'b1) @(negedge clk_i);
    `CHK({pd_mode, buf_en, refresh_en}, {m, 1'b0, sr})
    n = 0;
    while (rx_en !== 1'b0) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n, int'(CKELCK_CYC))
    `CHK(low_pwr, 1'b0)
    @(posedge clk_i);
    op_busy <= 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK(low_pwr, 1'b1)
    wb(1'b0, REG_STATUS, 32'h0, rd);
    `CHK(rd[7:0], {exp_term, sr, 3'b100, m, 1'b1})
  endtask

  task automatic wake;
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    @(negedge clk_i);
    while (pd_o !== 1'b0) @(negedge clk_i);
    `CHK({buf_en, rx_en, cmd_en, refresh_en, low_pwr}, 5'b11010)
    n = 0;
    while (cmd_en !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n, int'(XP_CYC))
    `CHK(pd_mode, MODE_NONE)
  endtask

  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [3:0] c;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({pd_o, pd_mode, buf_en, rx_en, cmd_en, wb_ack}, {1'b1, MODE_IDLE, 4'h0})
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h0C, 32'h0, rd);
    `CHK(rd, 32'h0)
    // Termination follows setting, enable and supply, in power-down and after wake
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      c = (i == 4) ? 4'h9 : seed[3:0];
      @(posedge clk_i);
      vddq_ok <= seed[4] | (i == 4);
      exp_term = (c[2:0] != 3'h0) & c[3] & (seed[4] | (i == 4));
      wb(1'b1, REG_CTRL, {28'h0, c}, rd);
      repeat (3) @(negedge clk_i);
      `CHK(term_en, exp_term)
      if (i == 2) begin
        wake();
      end
    end
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, 32'h9)
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      power_down(i % 3 == 2, (i % 3 == 1) | ((i % 3 == 2) & seed[0]));
      wake();
    end
    wb(1'b0, REG_ERR, 32'h0, rd);
    `CHK(rd, 32'h0)
    // Short low pulse, then command inside exit latency
    @(posedge clk_i);
    fault <= 1'b1;
    go <= 1'b0;
    @(posedge clk_i);
    go <= 1'b1;
    repeat (20) @(posedge clk_i);
    fault <= 1'b0;
    wb(1'b0, REG_ERR, 32'h0, rd);
    `CHK(rd, 32'h3)
    wb(1'b1, REG_ERR, 32'h3, rd);
    wb(1'b0, REG_ERR, 32'h0, rd);
    `CHK(rd, 32'h0)
    wrap_up();
  end
endmodule
`default_nettype wire
